// ### include/axis_wrap_params.svh
`ifndef AXIS_WRAP_PARAMS_SVH
`define AXIS_WRAP_PARAMS_SVH

// register byte addresses
`define OFF_REPEAT_DISTANCE 8'h00
`define OFF_WRAP_OPTION 8'h04
`define OFF_REV_LIMIT_SEL 8'h08
`define OFF_REV_JOG_SEL 8'h0C
`define OFF_SPEED 8'h10
`define OFF_ACCEL 8'h14
`define OFF_CMD_VALUE 8'h18
`define OFF_COMMAND 8'h1C
`define OFF_DEMANDED_POS 8'h20
`define OFF_MEASURED_POS 8'h24
`define OFF_DISTANCE_TO_GO 8'h28
`define OFF_AXIS_STATE 8'h2C

// reset values
`define REPEAT_DISTANCE_AXIS0 32'h8000_0000
`define REPEAT_DISTANCE_OTHER 32'h004C_4B40
`define WRAP_OPT_RESET 2'h0
`define SEL_NONE 8'hFF
`define SPEED_RESET 32'h0000_03E8
`define ACCEL_RESET 32'h0000_000A

// selector codes
`define SEL_LOCAL_MAX 8'h07
`define SEL_PROHIBIT 8'h13

// field positions
`define BIT_POSITIVE_RANGE 0
`define BIT_END_REPEAT 1
`define BIT_REV_LIMIT 5

// command codes written to the command register
`define CMD_REVERSE 3'h1
`define CMD_CANCEL 3'h2
`define CMD_FAST_HALT 3'h3
`define CMD_DEFINE_POS 3'h4
`define CMD_OFFSET_POS 3'h5
`define CMD_ABS_MOVE 3'h6
`define CMD_MODIFY_END 3'h7

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### include/axis_wrap_pkg.sv
package axis_wrap_pkg;

    typedef logic signed [33:0] pos_type;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_REV = 5'b00010,
        ST_JOG = 5'b00100,
        ST_MOVE = 5'b01000,
        ST_DECEL = 5'b10000
    } motion_state_type;

    typedef struct packed {
        logic [7:0] local_n;
        logic rev_prohibit_n;
        logic inhibit;
        logic origin_limit;
    } machine_in_type;

endpackage

// ### rtl/input_sync.sv
`timescale 1ns/100ps
`default_nettype none

module input_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // levels
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    // meta_r feeds q only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_r <= INIT;
            q <= INIT;
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule

`default_nettype wire

// ### rtl/axis_wrap_and_reverse_limit.sv
// Implementation choices: the register addresses and register access over AXI4-Lite.
`include "axis_wrap_params.svh"
`timescale 1ns/100ps
`default_nettype none

module axis_wrap_and_reverse_limit #(
    parameter int AXIS_INDEX = 0
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // machine and servo driver
    input wire axis_wrap_pkg::machine_in_type machine_in,
    input wire logic signed [15:0] enc_delta,
    input wire logic repeat_ended,
    output logic signed [31:0] speed_demand,
    output logic end_repeat_req
);
    import axis_wrap_pkg::*;

    localparam logic [31:0] REPEAT_DISTANCE_RESET =
        (AXIS_INDEX == 0) ? `REPEAT_DISTANCE_AXIS0 : `REPEAT_DISTANCE_OTHER;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = (old & ~m) | (nw & m);
    endfunction

    // one span step suffices for any end point within one span of the range
    function automatic pos_type wrap_into(input pos_type x, input pos_type lo,
                                          input pos_type hi, input pos_type span,
                                          input logic positive);
        logic over;
        over = positive ? (x >= hi) : (x > hi);
        if (over)
            wrap_into = x - span;
        else if (x < lo)
            wrap_into = x + span;
        else
            wrap_into = x;
    endfunction

    // registers
    logic [31:0] repeat_distance_r;
    logic [1:0] wrap_opt_r;
    logic [7:0] lim_sel_r;
    logic [7:0] jog_sel_r;
    logic [31:0] speed_r;
    logic [31:0] accel_r;
    logic [31:0] cmd_val_r;
    logic flag_rev_limit_r;
    pos_type dem_r;
    pos_type meas_r;
    pos_type target_r;
    pos_type vel_r;
    motion_state_type state_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    machine_in_type in_s;

    input_sync #(
        .WIDTH(11),
        .INIT(11'h7FC)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(machine_in),
        .q(in_s)
    );

    // bus decode
    wire wr_en = s_axi_awvalid & awready_r & s_axi_wvalid & wready_r;
    wire rd_en = s_axi_arvalid & arready_r;
    wire [7:0] wa = s_axi_awaddr;
    wire [7:0] ra = s_axi_araddr;
    wire wr_rep = wr_en & (wa == `OFF_REPEAT_DISTANCE);
    wire wr_opt = wr_en & (wa == `OFF_WRAP_OPTION);
    wire wr_lim = wr_en & (wa == `OFF_REV_LIMIT_SEL);
    wire wr_jog = wr_en & (wa == `OFF_REV_JOG_SEL);
    wire wr_spd = wr_en & (wa == `OFF_SPEED);
    wire wr_acc = wr_en & (wa == `OFF_ACCEL);
    wire wr_val = wr_en & (wa == `OFF_CMD_VALUE);
    wire wr_cmd = wr_en & (wa == `OFF_COMMAND);
    wire wr_sts = wr_en & (wa == `OFF_AXIS_STATE);
    wire wa_ro = (wa == `OFF_DEMANDED_POS) | (wa == `OFF_MEASURED_POS) |
                 (wa == `OFF_DISTANCE_TO_GO);
    wire wa_ok = wr_rep | wr_opt | wr_lim | wr_jog | wr_spd | wr_acc | wr_val | wr_cmd |
                 wr_sts | wa_ro;
    wire [31:0] wd = s_axi_wdata;
    wire [31:0] rep_w = merge(repeat_distance_r, wd, s_axi_wstrb);
    // top bit held clear so the profile never sees a negative rate
    wire [31:0] spd_w = merge(speed_r, wd, s_axi_wstrb);
    wire [31:0] acc_w = merge(accel_r, wd, s_axi_wstrb);
    wire [2:0] code = wd[2:0];
    wire cmd_rev = wr_cmd & (code == `CMD_REVERSE);
    wire cmd_stop = wr_cmd & ((code == `CMD_CANCEL) | (code == `CMD_FAST_HALT));
    wire cmd_def = wr_cmd & (code == `CMD_DEFINE_POS);
    wire cmd_off = wr_cmd & (code == `CMD_OFFSET_POS);
    wire cmd_abs = wr_cmd & (code == `CMD_ABS_MOVE);
    wire cmd_mod = wr_cmd & (code == `CMD_MODIFY_END);

    // selectors accept only legal codes; anything else leaves the old value
    wire lim_legal = (wd[7:0] <= `SEL_LOCAL_MAX) | (wd[7:0] == `SEL_PROHIBIT) |
                     (wd[7:0] == `SEL_NONE);
    wire jog_legal = (wd[7:0] <= `SEL_LOCAL_MAX) | (wd[7:0] == `SEL_NONE);

    // input selection, both active low
    wire lim_active = (lim_sel_r <= `SEL_LOCAL_MAX) ? ~in_s.local_n[lim_sel_r[2:0]] :
                      (lim_sel_r == `SEL_PROHIBIT) ? ~in_s.rev_prohibit_n : 1'b0;
    wire jog_active = (jog_sel_r <= `SEL_LOCAL_MAX) ? ~in_s.local_n[jog_sel_r[2:0]] :
                      1'b0;
    wire hard_stop = in_s.inhibit | in_s.origin_limit;

    // range arithmetic
    wire positive = wrap_opt_r[`BIT_POSITIVE_RANGE];
    wire pos_type hi = pos_type'({2'b00, repeat_distance_r});
    wire pos_type lo = positive ? pos_type'(0) : -hi;
    wire pos_type span = positive ? hi : (hi <<< 1);
    wire pos_type val = pos_type'(signed'(cmd_val_r));
    wire pos_type spd = pos_type'({2'b00, speed_r});
    wire pos_type acc = pos_type'({2'b00, accel_r});

    // motion profile
    wire pos_type proj = dem_r + vel_r;
    wire pos_type dtg = target_r - proj;
    wire pos_type vel_dn = vel_r - acc;
    wire pos_type vel_rev = (vel_dn < -spd) ? -spd : vel_dn;
    wire pos_type vel_dec = (vel_r > acc) ? vel_r - acc :
                            (vel_r < -acc) ? vel_r + acc : pos_type'(0);
    wire pos_type step = (dtg > spd) ? spd : (dtg < -spd) ? -spd : dtg;
    wire pos_type end_pos = wrap_into(val, lo, hi, span, positive);

    motion_state_type state_nxt;
    pos_type vel_nxt;
    always_comb
    begin
        state_nxt = state_r;
        vel_nxt = vel_r;
        case (state_r)
            ST_IDLE:
            begin
                vel_nxt = '0;
                if (cmd_rev & ~lim_active & ~hard_stop)
                    state_nxt = ST_REV;
                else if (cmd_abs)
                    state_nxt = ST_MOVE;
                else if (jog_active & ~lim_active & ~hard_stop)
                    state_nxt = ST_JOG;
            end
            ST_REV, ST_JOG:
            begin
                vel_nxt = vel_rev;
                if (lim_active | hard_stop)
                begin
                    vel_nxt = '0;
                    state_nxt = ST_IDLE;
                end
                else if (cmd_stop | ((state_r == ST_JOG) & ~jog_active))
                begin
                    vel_nxt = vel_dec;
                    state_nxt = ST_DECEL;
                end
            end
            ST_MOVE:
            begin
                vel_nxt = step;
                if (cmd_stop)
                begin
                    vel_nxt = vel_dec;
                    state_nxt = ST_DECEL;
                end
                else if (dtg == 0)
                    state_nxt = ST_IDLE;
            end
            ST_DECEL:
            begin
                vel_nxt = vel_dec;
                if (vel_dec == 0)
                    state_nxt = ST_IDLE;
            end
            default:
            begin
                vel_nxt = '0;
                state_nxt = ST_IDLE;
            end
        endcase
        // backward motion never survives an active reverse limit
        if (lim_active & (vel_nxt < 0))
        begin
            vel_nxt = '0;
            state_nxt = ST_IDLE;
        end
    end

    // position update and wrap; the shift is common to all, so the move is unaffected
    wire pos_type meas_a = meas_r + pos_type'(enc_delta);
    wire meas_over = positive ? (meas_a >= hi) : (meas_a > hi);
    wire pos_type adj = meas_over ? -span : (meas_a < lo) ? span : pos_type'(0);
    wire pos_type def_pos = end_pos;
    wire pos_type off_dem = wrap_into(proj + val, lo, hi, span, positive);
    wire pos_type off_meas = wrap_into(meas_a + val, lo, hi, span, positive);
    wire pos_type dem_nxt = cmd_def ? def_pos : cmd_off ? off_dem : proj + adj;
    wire pos_type meas_nxt = cmd_def ? def_pos : cmd_off ? off_meas : meas_a + adj;
    wire new_end = cmd_abs | (cmd_mod & (state_r == ST_MOVE));
    wire pos_type target_nxt = new_end ? end_pos : target_r + adj;

    // remaining distance is only meaningful inside a finite move
    wire pos_type distance_to_go = (state_r == ST_MOVE) ? target_r - dem_r : pos_type'(0);

    wire [31:0] state_word = {26'h0, flag_rev_limit_r, 5'h0};
    wire [31:0] rd_word =
        (ra == `OFF_REPEAT_DISTANCE) ? repeat_distance_r :
        (ra == `OFF_WRAP_OPTION) ? {30'h0, wrap_opt_r} :
        (ra == `OFF_REV_LIMIT_SEL) ? {{24{lim_sel_r[7]}}, lim_sel_r} :
        (ra == `OFF_REV_JOG_SEL) ? {{24{jog_sel_r[7]}}, jog_sel_r} :
        (ra == `OFF_SPEED) ? speed_r :
        (ra == `OFF_ACCEL) ? accel_r :
        (ra == `OFF_CMD_VALUE) ? cmd_val_r :
        (ra == `OFF_DEMANDED_POS) ? dem_r[31:0] :
        (ra == `OFF_MEASURED_POS) ? meas_r[31:0] :
        (ra == `OFF_DISTANCE_TO_GO) ? distance_to_go[31:0] :
        (ra == `OFF_AXIS_STATE) ? state_word : 32'h0000_0000;
    wire ra_ok = (ra <= `OFF_AXIS_STATE) & (ra[1:0] == 2'h0);

    // bus handshakes: one write and one read at a time
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= `RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            awready_r <= s_axi_awvalid & s_axi_wvalid & ~awready_r & ~bvalid_r;
            wready_r <= s_axi_awvalid & s_axi_wvalid & ~awready_r & ~bvalid_r;
            if (wr_en)
            begin
                bvalid_r <= 1'b1;
                bresp_r <= wa_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_r <= 1'b0;
            arready_r <= s_axi_arvalid & ~arready_r & ~rvalid_r;
            if (rd_en)
            begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_word;
                rresp_r <= ra_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            else if (s_axi_rready)
                rvalid_r <= 1'b0;
        end
    end

    // settings
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            repeat_distance_r <= REPEAT_DISTANCE_RESET;
            lim_sel_r <= `SEL_NONE;
            jog_sel_r <= `SEL_NONE;
            speed_r <= `SPEED_RESET;
            accel_r <= `ACCEL_RESET;
            cmd_val_r <= 32'h0000_0000;
        end
        else
        begin
            // a zero repeat distance would collapse the range
            if (wr_rep & (rep_w != 32'h0000_0000))
                repeat_distance_r <= rep_w;
            if (wr_lim & s_axi_wstrb[0] & lim_legal)
                lim_sel_r <= wd[7:0];
            if (wr_jog & s_axi_wstrb[0] & jog_legal)
                jog_sel_r <= wd[7:0];
            if (wr_spd)
                speed_r <= {1'b0, spd_w[30:0]};
            if (wr_acc)
                accel_r <= {1'b0, acc_w[30:0]};
            if (wr_val)
                cmd_val_r <= merge(cmd_val_r, wd, s_axi_wstrb);
        end
    end

    // flags: hardware set and host set both win over a same-cycle clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wrap_opt_r <= `WRAP_OPT_RESET;
            flag_rev_limit_r <= 1'b0;
        end
        else
        begin
            if (wr_opt & s_axi_wstrb[0])
                wrap_opt_r <= wd[1:0];
            else if (repeat_ended)
                wrap_opt_r[`BIT_END_REPEAT] <= 1'b0;
            if (lim_active)
                flag_rev_limit_r <= 1'b1;
            else if (wr_sts & s_axi_wstrb[0] & wd[`BIT_REV_LIMIT])
                flag_rev_limit_r <= 1'b0;
        end
    end

    // motion state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r <= ST_IDLE;
            vel_r <= '0;
            dem_r <= '0;
            meas_r <= '0;
            target_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            vel_r <= vel_nxt;
            dem_r <= dem_nxt;
            meas_r <= meas_nxt;
            target_r <= target_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign speed_demand = vel_r[31:0];
    assign end_repeat_req = wrap_opt_r[`BIT_END_REPEAT];

endmodule

`default_nettype wire

// ### test/axis_wrap_sva.sv
`timescale 1ns/100ps
`default_nettype none

module axis_wrap_sva (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // machine side
    input wire axis_wrap_pkg::machine_in_type machine_in,
    input wire logic repeat_ended,
    input wire logic signed [31:0] speed_demand,
    input wire logic end_repeat_req
);
    import axis_wrap_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence wr_offer;
        s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
    endsequence
    sequence wr_answer;
        s_axi_awready && s_axi_wready ##1 s_axi_bvalid && !s_axi_awready;
    endsequence

    wr_walk_a: assert property (wr_offer |=> wr_answer)
        else $error("write answer not on time");
    rd_walk_a: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready
        |=> s_axi_arready ##1 s_axi_rvalid) else $error("read answer not on time");
    aw_refuse_a: assert property (s_axi_awready |-> s_axi_wvalid && !s_axi_bvalid)
        else $error("write taken while refused");
    ar_refuse_a: assert property (s_axi_arready |-> s_axi_arvalid && !s_axi_rvalid)
        else $error("read taken while refused");
    bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response stuck");
    rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response stuck");
    rep_clear_a: assert property (repeat_ended && !s_axi_wready |=> !end_repeat_req)
        else $error("repeat request not cleared");
    rep_hold_a: assert property ($fell(end_repeat_req) |->
        $past(repeat_ended) || $past(s_axi_wready)) else $error("repeat request lost");
    inhibit_stop_a: assert property (machine_in.inhibit [*5] |-> speed_demand == 0)
        else $error("motion under inhibit");
    origin_stop_a: assert property (machine_in.origin_limit [*5] |-> speed_demand == 0)
        else $error("motion past origin limit");
    reset_quiet_a: assert property ($rose(aresetn) |-> !end_repeat_req)
        else $error("repeat request after reset");
endmodule

bind axis_wrap_and_reverse_limit axis_wrap_sva u_sva (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .machine_in, .repeat_ended, .speed_demand, .end_repeat_req
);

`default_nettype wire

// ### test/machine_model.sv
`timescale 1ns/100ps
`default_nettype none

module machine_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // levels from the bench
    input wire logic [7:0] local_n,
    input wire logic prohibit_n,
    input wire logic inhibit,
    input wire logic origin,
    input wire logic signed [15:0] step,
    // device side
    input wire logic end_req,
    output var axis_wrap_pkg::machine_in_type machine_in,
    output logic signed [15:0] enc_delta,
    output logic repeat_ended
);
    import axis_wrap_pkg::*;
    logic [3:0] cnt_r;
    assign machine_in = {local_n, prohibit_n, inhibit, origin};
    assign enc_delta = step;
    // the cam repeat winds down some cycles after the request, never at once
    always_ff @(posedge aclk)
    begin
        cnt_r <= (aresetn && end_req && !repeat_ended) ? cnt_r + 4'h1 : 4'h0;
        repeat_ended <= aresetn && end_req && cnt_r == 4'h7;
    end
endmodule

`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import axis_wrap_pkg::*;
    localparam logic signed [31:0] VNEG = 32'hFFFF_FF9C;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, repeat_ended, end_repeat_req, proh_n, inh, org;
    logic [7:0] s_axi_awaddr, s_axi_araddr, loc_n;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    machine_in_type machine_in;
    logic signed [15:0] enc_delta, step;
    logic signed [31:0] speed_demand;
    int failures, checked, cyc, n;

    axis_wrap_and_reverse_limit #(.AXIS_INDEX(0)) u_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .machine_in, .enc_delta,
        .repeat_ended, .speed_demand, .end_repeat_req
    );
    machine_model u_model (
        .aclk, .aresetn, .local_n(loc_n), .prohibit_n(proh_n), .inhibit(inh),
        .origin(org), .step, .end_req(end_repeat_req), .machine_in, .enc_delta,
        .repeat_ended
    );

    always #2.5 aclk = ~aclk;

    task give_verdict;
        if (failures == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            give_verdict;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic inr(input logic signed [31:0] v, lo, hi);
        chk({31'h0, (v >= lo) && (v <= hi)}, 32'h1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic aw_done, w_done;
        aw_done = 1'h0;
        w_done = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        // each channel is released only by its own ready
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'h1)
            begin
                aw_done = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wready === 1'h1)
            begin
                w_done = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e);
    endtask

    task automatic wz(input int lim);
        n = 0;
        while (speed_demand !== 32'h0 && n < lim)
        begin
            @(posedge aclk);
            n++;
        end
        chk(speed_demand, 32'h0);
    endtask

    task automatic push(input logic signed [15:0] s, input int cnt);
        step <= s;
        repeat (cnt) @(posedge aclk);
        step <= 16'h0;
        repeat (4) @(posedge aclk);
    endtask

    task automatic t_reset;
        rc(8'h00, 32'h8000_0000);
        rc(8'h04, 32'h0000_0000);
        rc(8'h08, 32'hFFFF_FFFF);
        rc(8'h0C, 32'hFFFF_FFFF);
        rc(8'h14, 32'h0000_000A);
        rc(8'h28, 32'h0000_0000);
    endtask

    task automatic t_sel;
        wr(8'h08, 32'h0000_0013, 2'h0);
        rc(8'h08, 32'h0000_0013);
        wr(8'h08, 32'h0000_0008, 2'h0);
        rc(8'h08, 32'h0000_0013);
        wr(8'h0C, 32'h0000_0013, 2'h0);
        rc(8'h0C, 32'hFFFF_FFFF);
        wr(8'h0C, 32'h0000_0003, 2'h0);
        rc(8'h0C, 32'h0000_0003);
        wr(8'h30, 32'h0000_0001, 2'h2);
        rc(8'h30, 32'h0000_0000);
        chk({30'h0, r}, 32'h0000_0002);
        wr(8'h28, 32'h0000_0005, 2'h0);
        rc(8'h28, 32'h0000_0000);
    endtask

    task automatic t_wrap;
        wr(8'h00, 32'h0000_0064, 2'h0);
        push(16'h0007, 50);
        rd(8'h24);
        inr(d, 32'hFFFF_FF9C, 32'h0000_0064);
        rc(8'h20, 32'hFFFF_FE70);
        wr(8'h04, 32'h0000_0001, 2'h0);
        push(16'hFFFD, 40);
        rd(8'h24);
        inr(d, 32'h0000_0000, 32'h0000_0064);
        rc(8'h20, 32'hFFFF_FF38);
    endtask

    task automatic t_endpt;
        wr(8'h18, 32'hFFFF_FFE2, 2'h0);
        wr(8'h1C, 32'h0000_0004, 2'h0);
        rc(8'h20, 32'h0000_0046);
        wr(8'h10, 32'h0000_0001, 2'h0);
        wr(8'h18, 32'h0000_0082, 2'h0);
        wr(8'h1C, 32'h0000_0006, 2'h0);
        rd(8'h28);
        chk({31'h0, d != 32'h0}, 32'h1);
        inr(d, 32'hFFFF_FFD8, 32'h0000_0028);
        wz(80);
        rc(8'h20, 32'h0000_001E);
        rc(8'h28, 32'h0000_0000);
        wr(8'h18, 32'h0000_0050, 2'h0);
        wr(8'h1C, 32'h0000_0005, 2'h0);
        rc(8'h20, 32'h0000_000A);
        rc(8'h24, 32'h0000_0032);
        wr(8'h1C, 32'h0000_0006, 2'h0);
        wr(8'h18, 32'hFFFF_FFBA, 2'h0);
        wr(8'h1C, 32'h0000_0007, 2'h0);
        wz(80);
        rc(8'h20, 32'h0000_001E);
        wr(8'h10, 32'h0000_0064, 2'h0);
    endtask

    task automatic t_repeat;
        wr(8'h04, 32'h0000_0003, 2'h0);
        chk({31'h0, end_repeat_req}, 32'h1);
        repeat (16) @(posedge aclk);
        chk({31'h0, end_repeat_req}, 32'h0);
        rc(8'h04, 32'h0000_0001);
    endtask

    task automatic t_stop(input int k);
        logic signed [31:0] p;
        wr(8'h1C, 32'h0000_0001, 2'h0);
        p = speed_demand;
        for (int i = 0; i < 30 && p !== VNEG; i++)
        begin
            @(posedge aclk);
            chk(p - speed_demand, 32'h0000_000A);
            p = speed_demand;
        end
        repeat (20) @(posedge aclk);
        chk(speed_demand, VNEG);
        case (k)
            0: wr(8'h1C, 32'h0000_0002, 2'h0);
            1: wr(8'h1C, 32'h0000_0003, 2'h0);
            2: inh <= 1'h1;
            3: org <= 1'h1;
            default: proh_n <= 1'h0;
        endcase
        if (k < 2)
            chk({31'h0, speed_demand != 32'h0}, 32'h1);
        wz(20);
        if (k >= 2)
            chk({31'h0, n <= 5}, 32'h1);
        rd(8'h2C);
        chk(d & 32'h0000_0020, (k == 4) ? 32'h0000_0020 : 32'h0);
        inh <= 1'h0;
        org <= 1'h0;
        proh_n <= 1'h1;
        repeat (4) @(posedge aclk);
        wr(8'h2C, 32'h0000_0020, 2'h0);
        rd(8'h2C);
        chk(d & 32'h0000_0020, 32'h0);
    endtask

    task automatic t_jog;
        loc_n <= 8'hFB;
        repeat (8) @(posedge aclk);
        chk(speed_demand, 32'h0);
        loc_n <= 8'hF7;
        repeat (8) @(posedge aclk);
        chk({31'h0, speed_demand[31]}, 32'h1);
        loc_n <= 8'hFF;
        wz(40);
    endtask

    initial
    begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
        {s_axi_arvalid, s_axi_rready, inh, org} = 4'h0;
        proh_n = 1'h1;
        s_axi_awaddr = 8'h0;
        s_axi_araddr = 8'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        loc_n = 8'hFF;
        step = 16'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset;
        t_sel;
        t_wrap;
        t_endpt;
        t_repeat;
        for (int k = 0; k < 5; k++)
            t_stop(k);
        t_jog;
        give_verdict;
    end
endmodule

`default_nettype wire
